// ===== logic/capture_frontend_pkg.sv
// Package: register map, field layout and timing constants of the capture front end
package capture_frontend_pkg;
   // ************************************************************
   // Register byte addresses (word aligned)
   // ************************************************************
   localparam logic [3:0] ADDR_MODE_CAPTURE = 4'h0;
   localparam logic [3:0] ADDR_OUTPUT_CTRL = 4'h4;
   localparam logic [3:0] ADDR_EVENT_STATUS = 4'h8;
   localparam logic [3:0] ADDR_EVENT_MASK = 4'hC;
   // ************************************************************
   // Mode register fields
   // ************************************************************
   localparam int FILT_LSB = 4;
   localparam int FILT_MSB = 7;
   localparam int DIV_LSB = 2;
   localparam int DIV_MSB = 3;
   localparam int CFG_LSB = 0;
   localparam int CFG_MSB = 1;
   localparam logic [15:0] MODE_MASK = 16'h00FF;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   // ************************************************************
   // Output control fields
   // ************************************************************
   localparam int EN_BIT = 0;
   localparam int MPOL_BIT = 1;
   localparam int CEN_BIT = 2;
   localparam int CPOL_BIT = 3;
   localparam logic [15:0] CTRL_MASK = 16'h000F;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ************************************************************
   // Event status bits
   // ************************************************************
   localparam int EV_CAPTURE = 0;
   localparam int EV_OVERCAPTURE = 1;
   localparam int EV_WIDTH = 2;
   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic [1:0] {
      CFG_OUTPUT = 2'b00,
      CFG_OWN = 2'b01,
      CFG_NEIGHBOUR = 2'b10,
      CFG_TRIGGER = 2'b11
   } chan_cfg_t;
   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_RSVD = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;
   // Dead-time sampling clock divider; the dead-time clock equals the core clock here
   localparam int DTS_DIV = 1;
   localparam int SAMPLE_CNT_W = 5;
   localparam int MATCH_CNT_W = 4;
   localparam int EDGE_CNT_W = 3;
endpackage

// ===== logic/input_noise_filter.sv
// Digital noise filter with selectable sampling rate and match count
`timescale 1ns/10ps
module input_noise_filter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic [3:0] input_filter_sel,
   // Data
   input wire logic selected_input,
   output logic own_filtered_input
);
   // ************************************************************
   // Filter code decode
   // ************************************************************
   // Returns {sample divider, match count}
   function automatic logic [9:0] decode(input logic [3:0] code);
      logic [4:0] dv;
      logic [4:0] n;
      dv = 5'h01;
      n = 5'h01;
      case (code)
         4'h0: begin dv = 5'h01; n = 5'h01; end
         4'h1: begin dv = 5'h01; n = 5'h02; end
         4'h2: begin dv = 5'h01; n = 5'h04; end
         4'h3: begin dv = 5'h01; n = 5'h08; end
         4'h4: begin dv = 5'h02; n = 5'h06; end
         4'h5: begin dv = 5'h02; n = 5'h08; end
         4'h6: begin dv = 5'h04; n = 5'h06; end
         4'h7: begin dv = 5'h04; n = 5'h08; end
         4'h8: begin dv = 5'h08; n = 5'h06; end
         4'h9: begin dv = 5'h08; n = 5'h08; end
         4'hA: begin dv = 5'h10; n = 5'h05; end
         4'hB: begin dv = 5'h10; n = 5'h06; end
         4'hC: begin dv = 5'h10; n = 5'h08; end
         4'hD: begin dv = 5'h10; n = 5'h05; end
         4'hE: begin dv = 5'h10; n = 5'h06; end
         default: begin dv = 5'h10; n = 5'h08; end
      endcase
      return {dv, n};
   endfunction

   logic [9:0] dec;
   logic [4:0] div_sel;
   logic [4:0] need;
   logic [4:0] pre_r;
   logic [4:0] match_r;
   logic cand_r;
   logic tick;
   logic no_filter;

   // A function result cannot be part-selected directly, so it lands in a net first
   assign dec = decode(input_filter_sel);
   assign div_sel = dec[9:5];
   assign need = dec[4:0];
   assign no_filter = (input_filter_sel == 4'h0);
   assign tick = (pre_r == 5'(div_sel - 5'h01));

   // ************************************************************
   // Sampling prescaler
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pre_r <= 5'h00;
      end else if (tick || pre_r >= div_sel) begin
         pre_r <= 5'h00;
      end else begin
         pre_r <= 5'(pre_r + 5'h01);
      end
   end

   // ************************************************************
   // Match counter: restarts when a sample leaves the candidate level
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cand_r <= 1'b0;
         match_r <= 5'h00;
         own_filtered_input <= 1'b0;
      end else if (no_filter) begin
         cand_r <= selected_input;
         match_r <= 5'h00;
         own_filtered_input <= selected_input;
      end else if (tick) begin
         if (selected_input != cand_r) begin
            cand_r <= selected_input;
            match_r <= 5'h01;
            if (need == 5'h01) begin
               own_filtered_input <= selected_input;
            end
         end else if (match_r < need) begin
            match_r <= 5'(match_r + 5'h01);
            if (5'(match_r + 5'h01) >= need) begin
               own_filtered_input <= cand_r;
            end
         end
      end
   end
endmodule

// ===== logic/timer_channel_capture_frontend.sv
// Channel 1 input-capture front end and output polarity/enable control
//
// Behaviour
// - Mode register: filter 7:4, divider 3:2, config 1:0
// - Edge passes after N stable samples
// - Code 0000 unfiltered; 0001 core clock, N=2
// - Capture every 1, 2, 4, 8 edges
// - Edge counter cleared while channel disabled
// - Config selects output, own, neighbour, trigger
// - Control register: enable, polarity, comp enable, comp polarity
// - Comp polarity one makes comp output low-active
// - Comp enable gates the complementary output
// - Output main polarity one inverts main output
// - Input polarity pair selects active edge
// - Trigger inverted only for falling setting
// - Channel enable gates capture or main output
// - Main output equals reference xor polarity
`timescale 1ns/10ps
module timer_channel_capture_frontend (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Channel inputs
   input wire logic own_raw_input,
   input wire logic neighbour_raw_input,
   input wire logic internal_trigger_input,
   input wire logic trigger_source_select,
   // Output path
   input wire logic raw_output_reference,
   output logic main_output,
   output logic main_output_en,
   output logic complementary_output,
   output logic complementary_output_en,
   // Capture results
   output logic capture_event,
   output logic external_trigger,
   output logic irq
);
   // ************************************************************
   // Registers
   // ************************************************************
   logic [15:0] mode_r;
   logic [15:0] ctrl_r;
   logic [capture_frontend_pkg::EV_WIDTH-1:0] status_r;
   logic [capture_frontend_pkg::EV_WIDTH-1:0] mask_r;
   logic ack_r;
   logic [2:0] edge_cnt_r;
   logic filt_d_r;
   logic capture_r;

   logic [3:0] input_filter_sel;
   logic [1:0] capture_prescale;
   logic [1:0] chan_config;
   logic chan_enable;
   logic main_polarity;
   logic comp_output_enable;
   logic comp_polarity;
   logic selected_input;
   logic own_filtered_input;
   logic rise;
   logic fall;
   logic active_edge;
   logic [2:0] div_mask;
   logic capture_nxt;
   logic is_input;
   logic wr_go;
   logic rd_go;
   logic lo_en;

   assign input_filter_sel = mode_r[capture_frontend_pkg::FILT_MSB:capture_frontend_pkg::FILT_LSB];
   assign capture_prescale = mode_r[capture_frontend_pkg::DIV_MSB:capture_frontend_pkg::DIV_LSB];
   assign chan_config = mode_r[capture_frontend_pkg::CFG_MSB:capture_frontend_pkg::CFG_LSB];
   assign chan_enable = ctrl_r[capture_frontend_pkg::EN_BIT];
   assign main_polarity = ctrl_r[capture_frontend_pkg::MPOL_BIT];
   assign comp_output_enable = ctrl_r[capture_frontend_pkg::CEN_BIT];
   assign comp_polarity = ctrl_r[capture_frontend_pkg::CPOL_BIT];
   assign is_input = (chan_config != capture_frontend_pkg::CFG_OUTPUT);

   // ************************************************************
   // Bus handshake: one wait cycle per access
   // ************************************************************
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_go = avs_write && ack_r;
   assign rd_go = avs_read && !ack_r;
   assign lo_en = avs_byteenable[0];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else if (ack_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= avs_read || avs_write;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Upper byte enable is irrelevant: bits above 7 are reserved in both registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= capture_frontend_pkg::MODE_RESET;
      end else if (wr_go && lo_en && avs_address == capture_frontend_pkg::ADDR_MODE_CAPTURE) begin
         // Config field follows the enable; a write while enabled is accepted as is
         mode_r <= avs_writedata[15:0] & capture_frontend_pkg::MODE_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= capture_frontend_pkg::CTRL_RESET;
      end else if (wr_go && lo_en && avs_address == capture_frontend_pkg::ADDR_OUTPUT_CTRL) begin
         ctrl_r <= avs_writedata[15:0] & capture_frontend_pkg::CTRL_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= '0;
      end else if (wr_go && lo_en && avs_address == capture_frontend_pkg::ADDR_EVENT_MASK) begin
         mask_r <= avs_writedata[capture_frontend_pkg::EV_WIDTH-1:0];
      end
   end

   // ************************************************************
   // Read data, registered; unmapped addresses read zero
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         case (avs_address)
            capture_frontend_pkg::ADDR_MODE_CAPTURE: avs_readdata <= {16'h0000, mode_r};
            capture_frontend_pkg::ADDR_OUTPUT_CTRL: avs_readdata <= {16'h0000, ctrl_r};
            capture_frontend_pkg::ADDR_EVENT_STATUS: begin
               avs_readdata <= {30'h0000_0000, status_r};
            end
            capture_frontend_pkg::ADDR_EVENT_MASK: begin
               avs_readdata <= {30'h0000_0000, mask_r};
            end
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Input selection
   // ************************************************************
   always_comb begin
      case (chan_config)
         capture_frontend_pkg::CFG_OWN: selected_input = own_raw_input;
         capture_frontend_pkg::CFG_NEIGHBOUR: selected_input = neighbour_raw_input;
         // Trigger source only meaningful with internal trigger selected
         capture_frontend_pkg::CFG_TRIGGER: begin
            selected_input = internal_trigger_input & trigger_source_select;
         end
         default: selected_input = 1'b0;
      endcase
   end

   input_noise_filter u_filter (
      .core_clk(core_clk),
      .rstn(rstn),
      .input_filter_sel(input_filter_sel),
      .selected_input(selected_input),
      .own_filtered_input(own_filtered_input)
   );

   // ************************************************************
   // Edge detection and polarity
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         filt_d_r <= 1'b0;
      end else begin
         filt_d_r <= own_filtered_input;
      end
   end

   assign rise = own_filtered_input && !filt_d_r;
   assign fall = !own_filtered_input && filt_d_r;

   always_comb begin
      case ({comp_polarity, main_polarity})
         capture_frontend_pkg::EDGE_RISE: active_edge = rise;
         capture_frontend_pkg::EDGE_FALL: active_edge = fall;
         capture_frontend_pkg::EDGE_BOTH: active_edge = rise || fall;
         default: active_edge = 1'b0;
      endcase
   end

   // Inverted only for the falling-edge setting
   assign external_trigger = own_filtered_input ^
      ({comp_polarity, main_polarity} == capture_frontend_pkg::EDGE_FALL);

   // ************************************************************
   // Capture divider
   // ************************************************************
   always_comb begin
      case (capture_prescale)
         2'b00: div_mask = 3'h0;
         2'b01: div_mask = 3'h1;
         2'b10: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   assign capture_nxt = chan_enable && is_input && active_edge &&
      ((edge_cnt_r & div_mask) == div_mask);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         edge_cnt_r <= 3'h0;
      end else if (!chan_enable) begin
         edge_cnt_r <= 3'h0;
      end else if (is_input && active_edge) begin
         edge_cnt_r <= 3'((edge_cnt_r + 3'h1) & div_mask);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         capture_r <= 1'b0;
      end else begin
         capture_r <= capture_nxt;
      end
   end

   assign capture_event = capture_r;

   // ************************************************************
   // Event status: set wins over write-one-to-clear
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= '0;
      end else begin
         if (wr_go && lo_en && avs_address == capture_frontend_pkg::ADDR_EVENT_STATUS) begin
            status_r <= status_r & ~avs_writedata[capture_frontend_pkg::EV_WIDTH-1:0];
         end
         if (capture_r) begin
            status_r[capture_frontend_pkg::EV_CAPTURE] <= 1'b1;
            if (status_r[capture_frontend_pkg::EV_CAPTURE]) begin
               status_r[capture_frontend_pkg::EV_OVERCAPTURE] <= 1'b1;
            end
         end
      end
   end

   assign irq = |(status_r & mask_r);

   // ************************************************************
   // Output polarity and enables
   // ************************************************************
   // Dead-time insertion lives outside; with both enabled each output just applies polarity
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         main_output <= 1'b0;
         main_output_en <= 1'b0;
         complementary_output <= 1'b0;
         complementary_output_en <= 1'b0;
      end else begin
         main_output_en <= chan_enable && !is_input;
         main_output <= (chan_enable && !is_input) ?
            (raw_output_reference ^ main_polarity) : 1'b0;
         complementary_output_en <= comp_output_enable && !is_input;
         complementary_output <= (comp_output_enable && !is_input) ?
            (raw_output_reference ^ comp_polarity) : 1'b0;
      end
   end
endmodule

// ===== verif/capture_frontend_assertions.sv
// Concurrent checks on the capture front end ports
`timescale 1ns/10ps
module capture_frontend_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Channel inputs
   input wire logic own_raw_input,
   input wire logic neighbour_raw_input,
   input wire logic internal_trigger_input,
   input wire logic trigger_source_select,
   // Output path
   input wire logic raw_output_reference,
   input wire logic main_output,
   input wire logic main_output_en,
   input wire logic complementary_output,
   input wire logic complementary_output_en,
   // Capture results
   input wire logic capture_event,
   input wire logic external_trigger,
   input wire logic irq
);
   // ****************************************
   // Port relations
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_req_first;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_read_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_wait_one_cycle: assert property (s_req_first |=> !avs_waitrequest)
      else $error("waitrequest held past the first request cycle");
   a_reserved_read_zero: assert property (s_read_done |-> avs_readdata[31:8] == 24'h00_0000 &&
      (avs_address != 4'h4 || avs_readdata[7:4] == 4'h0))
      else $error("reserved read bits not zero");
   a_main_off_low: assert property (!main_output_en |-> !main_output)
      else $error("main output driven while disabled");
   a_comp_off_low: assert property (!complementary_output_en |-> !complementary_output)
      else $error("complementary output driven while disabled");
   a_main_follows_ref: assert property (main_output_en && !complementary_output_en &&
      $changed(raw_output_reference) |=> main_output_en |-> $changed(main_output))
      else $error("main output ignored reference change");
   a_capture_no_output: assert property (capture_event |-> !main_output_en)
      else $error("capture while channel in output direction");
   a_capture_one_pulse: assert property (capture_event |=> !capture_event)
      else $error("capture event longer than one cycle");
   a_irq_needs_cause: assert property ($rose(irq) |-> $past(capture_event) ||
      $past(capture_event, 2) || $past(avs_write) || $past(avs_write, 2))
      else $error("interrupt rose without capture or write");
endmodule

bind timer_channel_capture_frontend capture_frontend_assertions chk (.*);

// ===== verif/input_source_model.sv
// Pin-side model of the channel input sources
`timescale 1ns/10ps
module input_source_model (
   // Clock
   input wire logic core_clk,
   // Source lines
   output logic own_raw_input,
   output logic neighbour_raw_input,
   output logic internal_trigger_input
);
   // ****************************************
   // Line drivers
   // ****************************************
   logic [2:0] line_r = 3'b000;
   assign {internal_trigger_input, neighbour_raw_input, own_raw_input} = line_r;
   // Only one line moves, so a wrongly selected source shows no edges
   task automatic pulses(input int sel, input int n, input int hi, input int lo);
      repeat (n) begin
         @(posedge core_clk);
         line_r[sel] <= 1'b1;
         repeat (hi) @(posedge core_clk);
         line_r[sel] <= 1'b0;
         repeat (lo - 1) @(posedge core_clk);
      end
   endtask
   task automatic hold(input int sel, input logic v);
      @(posedge core_clk);
      line_r[sel] <= v;
   endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the capture front end
`timescale 1ns/10ps
module testbench;
   // ****************************************
   // Signals and instances
   // ****************************************
   localparam logic [3:0] A_MODE = capture_frontend_pkg::ADDR_MODE_CAPTURE;
   localparam logic [3:0] A_CTRL = capture_frontend_pkg::ADDR_OUTPUT_CTRL;
   localparam logic [3:0] A_STAT = capture_frontend_pkg::ADDR_EVENT_STATUS;
   localparam logic [3:0] A_MASK = capture_frontend_pkg::ADDR_EVENT_MASK;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic own_raw_input;
   logic neighbour_raw_input;
   logic internal_trigger_input;
   logic trigger_source_select = 1'b0;
   logic raw_output_reference = 1'b0;
   logic main_output;
   logic main_output_en;
   logic complementary_output;
   logic complementary_output_en;
   logic capture_event;
   logic external_trigger;
   logic irq;
   logic [31:0] rd;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int caps = 0;
   timer_channel_capture_frontend dut (.*);
   input_source_model src (
      .core_clk(core_clk),
      .own_raw_input(own_raw_input),
      .neighbour_raw_input(neighbour_raw_input),
      .internal_trigger_input(internal_trigger_input)
   );
   initial forever #12.5 core_clk = ~core_clk;
   // Ceiling well above the roughly 1600 cycles the tests need
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (capture_event === 1'b1) caps <= caps + 1;
      if (cycles == 40000) begin
         num_errors++;
         finish_test();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic finish_test();
      if (num_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic is_wr, input logic [3:0] addr, input logic [31:0] data);
      @(posedge core_clk);
      avs_address <= addr;
      avs_writedata <= data;
      avs_write <= is_wr;
      avs_read <= !is_wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp, input string what);
      bus(1'b0, addr, 32'h0000_0000);
      check(what, exp, rd);
   endtask
   task automatic cap_run(input logic [7:0] mode, input logic [3:0] ctrl, input int sel,
         input int n, input int hi, input int lo, input int exp, input string what);
      bus(1'b1, A_MODE, {24'h00_0000, mode});
      bus(1'b1, A_CTRL, {28'h000_0000, ctrl});
      repeat (4) @(posedge core_clk);
      caps = 0;
      src.pulses(sel, n, hi, lo);
      repeat (20) @(posedge core_clk);
      check(what, 32'(exp), 32'(caps));
      bus(1'b1, A_CTRL, 32'h0000_0000);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_registers();
      rd_chk(A_MODE, 32'h0000_0000, "mode reset");
      rd_chk(A_CTRL, 32'h0000_0000, "control reset");
      rd_chk(A_MASK, 32'h0000_0000, "mask reset");
      bus(1'b1, A_MODE, 32'hffff_ffff);
      rd_chk(A_MODE, 32'h0000_00ff, "mode fields");
      bus(1'b1, A_CTRL, 32'hffff_ffff);
      rd_chk(A_CTRL, 32'h0000_000f, "control fields");
      avs_byteenable <= 4'he;
      bus(1'b1, A_CTRL, 32'h0000_0000);
      avs_byteenable <= 4'hf;
      rd_chk(A_CTRL, 32'h0000_000f, "lane off write");
      bus(1'b1, 4'h1, 32'h0000_00ff);
      rd_chk(4'h1, 32'h0000_0000, "unmapped read");
      bus(1'b1, A_CTRL, 32'h0000_0000);
      bus(1'b1, A_MODE, 32'h0000_0000);
   endtask
   task automatic t_outputs();
      logic [3:0] c;
      logic [3:0] cases [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hc};
      foreach (cases[i]) for (int r = 0; r < 2; r++) begin
         c = cases[i];
         raw_output_reference <= r[0];
         bus(1'b1, A_CTRL, {28'h000_0000, c});
         repeat (3) @(posedge core_clk);
         check("main enable", 32'(c[0]), 32'(main_output_en));
         check("main output", 32'(c[0] & (r[0] ^ c[1])), 32'(main_output));
         check("comp enable", 32'(c[2]), 32'(complementary_output_en));
         check("comp output", 32'(c[2] & (r[0] ^ c[3])), 32'(complementary_output));
      end
      bus(1'b1, A_CTRL, 32'h0000_0000);
   endtask
   task automatic t_capture();
      for (int d = 0; d < 4; d++)
         cap_run({4'h0, d[1:0], 2'b01}, 4'h1, 0, 8, 2, 12, 8 >> d, "prescaled");
      cap_run(8'h0d, 4'h1, 0, 5, 2, 12, 0, "short of eight");
      cap_run(8'h0d, 4'h1, 0, 3, 2, 12, 0, "divider cleared");
      cap_run(8'h02, 4'h3, 1, 3, 2, 12, 3, "neighbour falling");
      cap_run(8'h01, 4'hb, 0, 3, 2, 12, 6, "both edges");
      cap_run(8'h03, 4'h1, 2, 2, 2, 12, 0, "trigger unselected");
      trigger_source_select <= 1'b1;
      cap_run(8'h03, 4'h1, 2, 2, 2, 12, 2, "trigger source");
      trigger_source_select <= 1'b0;
      cap_run(8'h01, 4'h0, 0, 2, 2, 12, 0, "channel off");
      cap_run(8'h01, 4'h1, 0, 3, 1, 12, 3, "unfiltered glitch");
      cap_run(8'h11, 4'h1, 0, 3, 1, 12, 0, "one sample glitch");
      cap_run(8'h11, 4'h1, 0, 6, 1, 1, 0, "chatter");
      cap_run(8'h11, 4'h1, 0, 3, 4, 12, 3, "stable pulses");
   endtask
   task automatic t_irq();
      bus(1'b1, A_STAT, 32'h0000_0003);
      bus(1'b1, A_MASK, 32'h0000_0001);
      cap_run(8'h01, 4'h1, 0, 1, 2, 12, 1, "single capture");
      check("irq raised", 32'h0000_0001, 32'(irq));
      rd_chk(A_STAT, 32'h0000_0001, "status set");
      bus(1'b1, A_STAT, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      check("irq cleared", 32'h0000_0000, 32'(irq));
      rd_chk(A_STAT, 32'h0000_0000, "status cleared");
      bus(1'b1, A_MASK, 32'h0000_0000);
      cap_run(8'h01, 4'h1, 0, 1, 2, 12, 1, "masked capture");
      check("irq masked", 32'h0000_0000, 32'(irq));
      rd_chk(A_STAT, 32'h0000_0001, "masked status");
      bus(1'b1, A_STAT, 32'h0000_0001);
   endtask
   task automatic t_trigger();
      logic [3:0] pol [3] = '{4'h1, 4'h3, 4'hb};
      logic exp [3] = '{1'b1, 1'b0, 1'b1};
      bus(1'b1, A_MODE, 32'h0000_0001);
      src.hold(0, 1'b1);
      foreach (pol[i]) begin
         bus(1'b1, A_CTRL, {28'h000_0000, pol[i]});
         repeat (4) @(posedge core_clk);
         check("external trigger", 32'(exp[i]), 32'(external_trigger));
      end
      bus(1'b1, A_CTRL, 32'h0000_0000);
      src.hold(0, 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      t_registers();
      t_outputs();
      t_capture();
      t_irq();
      t_trigger();
      finish_test();
   end
endmodule
